// File: logic/ttc_pkg.sv
// Package of constants and state types for the triple timer counter.
package ttc_pkg;
  // Word byte addresses of the registers on the Wishbone port.
  localparam logic [7:0] ADR_TCTRL = 8'h00;
  localparam logic [7:0] ADR_TMODE = 8'h04;
  localparam logic [7:0] ADR_T0LO = 8'h08;
  localparam logic [7:0] ADR_T0HI = 8'h0C;
  localparam logic [7:0] ADR_T1LO = 8'h10;
  localparam logic [7:0] ADR_T1HI = 8'h14;
  localparam logic [7:0] ADR_T2CTRL = 8'h18;
  localparam logic [7:0] ADR_T2LO = 8'h1C;
  localparam logic [7:0] ADR_T2HI = 8'h20;
  localparam logic [7:0] ADR_CAPLO = 8'h24;
  localparam logic [7:0] ADR_CAPHI = 8'h28;
  localparam logic [7:0] ADR_BAUDB = 8'h2C;
  // Bit positions inside timer_control.
  localparam int TC_T1F = 7;
  localparam int TC_T1R = 6;
  localparam int TC_T0F = 5;
  localparam int TC_T0R = 4;
  localparam int TC_X1F = 3;
  localparam int TC_X1T = 2;
  localparam int TC_X0F = 1;
  localparam int TC_X0T = 0;
  // Bit positions inside timer_mode_select.
  localparam int TM_G1 = 7;
  localparam int TM_CT1 = 6;
  localparam int TM_G0 = 3;
  localparam int TM_CT0 = 2;
  // Bit positions inside third_timer_control.
  localparam int T2_OVF = 7;
  localparam int T2_EXF = 6;
  localparam int T2_RXA = 5;
  localparam int T2_TXA = 4;
  localparam int T2_EXEN = 3;
  localparam int T2_RUN = 2;
  localparam int T2_CT = 1;
  localparam int T2_CAP = 0;
  // Bit positions of the second serial port baud source bits.
  localparam int BB_RXB = 1;
  localparam int BB_TXB = 0;
  // Mode codes of the two mode bits.
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RL8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  // Reset value of every register byte.
  localparam logic [7:0] RST_BYTE = 8'h00;
  // A machine cycle is six clocks; the counter wraps at the last one.
  localparam int MC_CLKS = 6;
  localparam logic [2:0] MC_LAST = 3'(MC_CLKS - 1);
  // Indices of the sampled pins in the sample vector.
  localparam int PN_CA = 0;
  localparam int PN_CB = 1;
  localparam int PN_C2 = 2;
  localparam int PN_TR = 3;
  localparam int PN_XA = 4;
  localparam int PN_XB = 5;
  // All state of the block, registered as one word.
  typedef struct packed {
    logic [2:0] mc;
    logic [7:0] timer_control;
    logic [7:0] timer_mode_select;
    logic [7:0] tl0;
    logic [7:0] th0;
    logic [7:0] tl1;
    logic [7:0] th1;
    logic [7:0] third_timer_control;
    logic [7:0] tl2;
    logic [7:0] th2;
    logic [7:0] rl;
    logic [7:0] rh;
    logic [1:0] baudb;
    logic [5:0] smp;
    logic ack;
    logic [7:0] rdat;
    logic t1bp;
    logic t2bp;
  } ttc_state_t;
endpackage

// File: logic/ttc_top.sv
// Three timer counters with a classic Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module ttc_top
  import ttc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic third_count_pin_i,
  input wire logic third_trigger_pin_i,
  input wire logic ext_irq_pin_a_n_i,
  input wire logic ext_irq_pin_b_n_i,
  input wire logic t0_vector_i,
  input wire logic t1_vector_i,
  input wire logic ext_irq0_done_i,
  input wire logic ext_irq1_done_i,
  output logic t0_irq_o,
  output logic t1_irq_o,
  output logic ext_irq0_o,
  output logic ext_irq1_o,
  output logic t2_irq_o,
  output logic t1_baud_pulse_o,
  output logic t2_baud_pulse_o
);

  // Present state and its next value.
  ttc_state_t q;
  ttc_state_t d;

  // Machine-cycle strobe, one clock in six.
  logic tick;
  // Falling edges seen between two machine-cycle samples.
  logic [5:0] fall;
  // Current level of all sampled pins.
  logic [5:0] pins;
  // Bus request taken this cycle, and a byte write.
  logic acc;
  logic wr;
  // Count enables of the three timers.
  logic inc0;
  logic inc1;
  logic inc2;
  // Overflow events of the timers this cycle.
  logic ovf0;
  logic ovf1;
  logic ovf2;
  logic ovf0h;
  // Timer 2 baud mode and trigger event.
  logic baud2;
  logic trig2;
  // Flag set requests gathered from the counters.
  logic [7:0] set_tc;
  logic [7:0] set_t2;
  // Results of the shared step function, the split byte sums and the timer 2 sum.
  logic [16:0] r0;
  logic [16:0] r1;
  logic [8:0] s0l;
  logic [8:0] s0h;
  logic [16:0] c2;

  // One increment of a timer in modes 0 to 2; top bit is overflow.
  // Mode 0 leaves the upper three low bits alone, so their value
  // is whatever software last wrote and should be ignored.
  function automatic logic [16:0] ttc_step(
    input logic [1:0] m,
    input logic [7:0] h,
    input logic [7:0] l
  );
    logic [5:0] p;
    logic [8:0] hh;
    logic [16:0] r;
    p = {1'b0, l[4:0]} + 6'h01;
    hh = {1'b0, h} + {8'h00, p[5]};
    r = {1'b0, h, l};
    unique case (m)
      MODE_13: begin
        r = {hh[8], hh[7:0], l[7:5], p[4:0]};
      end
      MODE_16: begin
        r = {1'b0, h, l} + 17'h00001;
      end
      MODE_RL8: begin
        if (l == 8'hFF) begin
          r = {1'b1, h, h};
        end else begin
          r = {1'b0, h, l + 8'h01};
        end
      end
      MODE_SPLIT: begin
        r = {1'b0, h, l};
      end
    endcase
    return r;
  endfunction

  // Next-state logic: counting first, then bus writes, then the
  // clears, and the hardware sets last so that a set always wins.
  always_comb begin
    d = q;
    d.t1bp = 1'b0;
    d.t2bp = 1'b0;
    set_tc = 8'h00;
    set_t2 = 8'h00;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf2 = 1'b0;
    ovf0h = 1'b0;
    trig2 = 1'b0;
    r0 = 17'h00000;
    r1 = 17'h00000;
    s0l = 9'h000;
    s0h = 9'h000;
    c2 = {1'b0, q.th2, q.tl2} + 17'h00001;
    // Machine cycle divider.
    tick = (q.mc == MC_LAST);
    d.mc = tick ? 3'h0 : q.mc + 3'h1;
    // Pins are sampled once per machine cycle.
    pins = {ext_irq_pin_b_n_i, ext_irq_pin_a_n_i, third_trigger_pin_i,
            third_count_pin_i, count_pin_b_i, count_pin_a_i};
    fall = q.smp & ~pins & {6{tick}};
    if (tick) begin
      d.smp = pins;
    end
    // Timer 0 and 1 enables: run bit and gate, then timer or counter.
    inc0 = tick & q.timer_control[TC_T0R]
         & (~q.timer_mode_select[TM_G0] | ext_irq_pin_a_n_i)
         & (q.timer_mode_select[TM_CT0] ? fall[PN_CA] : 1'b1);
    inc1 = tick & q.timer_control[TC_T1R]
         & (~q.timer_mode_select[TM_G1] | ext_irq_pin_b_n_i)
         & (q.timer_mode_select[TM_CT1] ? fall[PN_CB] : 1'b1);
    // Timer 0 counting in the selected mode.
    if (q.timer_mode_select[1:0] == MODE_SPLIT) begin
      // Low byte keeps timer 0 controls; high byte counts cycles.
      s0l = {1'b0, q.tl0} + 9'h001;
      s0h = {1'b0, q.th0} + 9'h001;
      if (inc0) begin
        d.tl0 = s0l[7:0];
        ovf0 = s0l[8];
      end
      if (tick & q.timer_control[TC_T1R]) begin
        d.th0 = s0h[7:0];
        ovf0h = s0h[8];
      end
    end else begin
      r0 = ttc_step(q.timer_mode_select[1:0], q.th0, q.tl0);
      if (inc0) begin
        d.th0 = r0[15:8];
        d.tl0 = r0[7:0];
        ovf0 = r0[16];
      end
    end
    // Timer 1 holds in its mode 3, as if stopped.
    r1 = ttc_step(q.timer_mode_select[5:4], q.th1, q.tl1);
    if (inc1 && q.timer_mode_select[5:4] != MODE_SPLIT) begin
      d.th1 = r1[15:8];
      d.tl1 = r1[7:0];
      ovf1 = r1[16];
    end
    // Timer 1 overflow always feeds the baud pulse; its flag is
    // taken over by the high byte of a split timer 0.
    d.t1bp = ovf1;
    set_tc[TC_T0F] = ovf0;
    if (q.timer_mode_select[1:0] == MODE_SPLIT) begin
      set_tc[TC_T1F] = ovf0h;
    end else begin
      set_tc[TC_T1F] = ovf1;
    end
    // External interrupts: edge mode latches a sampled fall,
    // level mode follows the sampled pin.
    if (q.timer_control[TC_X0T]) begin
      set_tc[TC_X0F] = fall[PN_XA];
    end else begin
      set_tc[TC_X0F] = tick & ~ext_irq_pin_a_n_i;
    end
    if (q.timer_control[TC_X1T]) begin
      set_tc[TC_X1F] = fall[PN_XB];
    end else begin
      set_tc[TC_X1F] = tick & ~ext_irq_pin_b_n_i;
    end
    // Timer 2 counting, baud, capture and reload.
    baud2 = q.third_timer_control[T2_RXA] | q.third_timer_control[T2_TXA]
          | q.baudb[BB_RXB] | q.baudb[BB_TXB];
    inc2 = tick & q.third_timer_control[T2_RUN]
         & (q.third_timer_control[T2_CT] ? fall[PN_C2] : 1'b1);
    trig2 = fall[PN_TR] & q.third_timer_control[T2_EXEN];
    if (inc2) begin
      d.th2 = c2[15:8];
      d.tl2 = c2[7:0];
      ovf2 = c2[16];
    end
    if (baud2) begin
      // Baud mode reloads on overflow only and never raises the overflow flag.
      if (ovf2) begin
        d.th2 = q.rh;
        d.tl2 = q.rl;
      end
      d.t2bp = ovf2;
      set_t2[T2_EXF] = trig2;
    end else if (q.third_timer_control[T2_CAP]) begin
      set_t2[T2_OVF] = ovf2;
      if (trig2) begin
        d.rl = q.tl2;
        d.rh = q.th2;
        set_t2[T2_EXF] = 1'b1;
      end
    end else begin
      set_t2[T2_OVF] = ovf2;
      if (ovf2 | trig2) begin
        d.th2 = q.rh;
        d.tl2 = q.rl;
      end
      set_t2[T2_EXF] = trig2;
    end
    // Bus slave: take a request, answer one cycle later.
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    d.ack = acc;
    // Read data is latched when the request is taken.
    unique case (wb_adr_i)
      ADR_TCTRL: d.rdat = q.timer_control;
      ADR_TMODE: d.rdat = q.timer_mode_select;
      ADR_T0LO: d.rdat = q.tl0;
      ADR_T0HI: d.rdat = q.th0;
      ADR_T1LO: d.rdat = q.tl1;
      ADR_T1HI: d.rdat = q.th1;
      ADR_T2CTRL: d.rdat = q.third_timer_control;
      ADR_T2LO: d.rdat = q.tl2;
      ADR_T2HI: d.rdat = q.th2;
      ADR_CAPLO: d.rdat = q.rl;
      ADR_CAPHI: d.rdat = q.rh;
      ADR_BAUDB: d.rdat = {6'h00, q.baudb};
      default: d.rdat = 8'h00;
    endcase
    if (!acc) begin
      d.rdat = q.rdat;
    end
    // Writes override the counters; the run bit never touches them.
    if (wr) begin
      unique case (wb_adr_i)
        ADR_TCTRL: d.timer_control = wb_dat_i[7:0];
        ADR_TMODE: d.timer_mode_select = wb_dat_i[7:0];
        ADR_T0LO: d.tl0 = wb_dat_i[7:0];
        ADR_T0HI: d.th0 = wb_dat_i[7:0];
        ADR_T1LO: d.tl1 = wb_dat_i[7:0];
        ADR_T1HI: d.th1 = wb_dat_i[7:0];
        ADR_T2CTRL: d.third_timer_control = wb_dat_i[7:0];
        ADR_T2LO: d.tl2 = wb_dat_i[7:0];
        ADR_T2HI: d.th2 = wb_dat_i[7:0];
        ADR_CAPLO: d.rl = wb_dat_i[7:0];
        ADR_CAPHI: d.rh = wb_dat_i[7:0];
        ADR_BAUDB: d.baudb = wb_dat_i[1:0];
        default: d.rdat = d.rdat;
      endcase
    end
    // Clears by vectoring, by the processed interrupt, or by a high sampled pin in level mode.
    if (t0_vector_i) begin
      d.timer_control[TC_T0F] = 1'b0;
    end
    if (t1_vector_i) begin
      d.timer_control[TC_T1F] = 1'b0;
    end
    if (ext_irq0_done_i | (~q.timer_control[TC_X0T] & tick & ext_irq_pin_a_n_i)) begin
      d.timer_control[TC_X0F] = 1'b0;
    end
    if (ext_irq1_done_i | (~q.timer_control[TC_X1T] & tick & ext_irq_pin_b_n_i)) begin
      d.timer_control[TC_X1F] = 1'b0;
    end
    // Hardware sets come last and win over any clear.
    d.timer_control = d.timer_control | set_tc;
    d.third_timer_control = d.third_timer_control | set_t2;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o = {24'h000000, q.rdat};
  assign wb_ack_o = q.ack;
  assign t0_irq_o = q.timer_control[TC_T0F];
  assign t1_irq_o = q.timer_control[TC_T1F];
  assign ext_irq0_o = q.timer_control[TC_X0F];
  assign ext_irq1_o = q.timer_control[TC_X1F];
  assign t2_irq_o = q.third_timer_control[T2_OVF] | q.third_timer_control[T2_EXF];
  assign t1_baud_pulse_o = q.t1bp;
  assign t2_baud_pulse_o = q.t2bp;

  // Checks on the counters and flags.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A stopped timer 0 outside mode 3 keeps its bytes.
  property p_t0_stop;
    (!q.timer_control[TC_T0R] && q.timer_mode_select[1:0] != MODE_SPLIT && !wr)
      |=> (q.tl0 == $past(q.tl0) && q.th0 == $past(q.th0));
  endproperty
  a_t0_stop: assert property (p_t0_stop)
    else $error("timer 0 moved while stopped");

  // Timer 1 in mode 3 holds even with its run bit set.
  property p_t1_hold;
    (q.timer_mode_select[5:4] == MODE_SPLIT && !wr) |=> $stable(q.tl1) && $stable(q.th1);
  endproperty
  a_t1_hold: assert property (p_t1_hold)
    else $error("timer 1 moved in mode 3");

  // Overflow of timer 0 shows as a flag on the next cycle.
  property p_t0_flag;
    ovf0 |=> q.timer_control[TC_T0F];
  endproperty
  a_t0_flag: assert property (p_t0_flag)
    else $error("timer 0 flag not set");

  // Vectoring with no new overflow clears the flag.
  property p_t0_clr;
    (t0_vector_i && !ovf0 && !wr) |=> !q.timer_control[TC_T0F];
  endproperty
  a_t0_clr: assert property (p_t0_clr)
    else $error("timer 0 flag not cleared");

  // Mode 2 overflow reloads the low byte from the high byte.
  property p_t0_rl8;
    (ovf0 && q.timer_mode_select[1:0] == MODE_RL8 && !wr)
      |=> (q.tl0 == $past(q.th0) && $stable(q.th0));
  endproperty
  a_t0_rl8: assert property (p_t0_rl8)
    else $error("mode 2 reload wrong");

  // Timer 2 auto-reload on rollover.
  property p_t2_rl;
    (ovf2 && !baud2 && !q.third_timer_control[T2_CAP] && !wr)
      |=> ({q.th2, q.tl2} == {$past(q.rh), $past(q.rl)})
          && q.third_timer_control[T2_OVF];
  endproperty
  a_t2_rl: assert property (p_t2_rl)
    else $error("timer 2 reload wrong");

  // Capture copies the count and sets the external flag.
  sequence s_cap;
    trig2 && q.third_timer_control[T2_CAP] && !baud2 && !wr;
  endsequence
  property p_t2_cap;
    s_cap |=> (q.rl == $past(q.tl2) && q.rh == $past(q.th2)
               && q.third_timer_control[T2_EXF]);
  endproperty
  a_t2_cap: assert property (p_t2_cap)
    else $error("timer 2 capture wrong");

  // Baud mode never raises the timer 2 overflow flag.
  property p_t2_baud;
    (baud2 && !q.third_timer_control[T2_OVF] && !wr) |=> !q.third_timer_control[T2_OVF];
  endproperty
  a_t2_baud: assert property (p_t2_baud)
    else $error("timer 2 flag set in baud mode");

  // A running 16-bit timer 0 counts one per machine cycle.
  property p_t0_tick;
    (tick && q.timer_control[TC_T0R] && !q.timer_mode_select[TM_G0] && !q.timer_mode_select[TM_CT0]
     && q.timer_mode_select[1:0] == MODE_16 && !wr)
      |=> ({q.th0, q.tl0} == $past({q.th0, q.tl0}) + 16'h0001);
  endproperty
  a_t0_tick: assert property (p_t0_tick)
    else $error("timer 0 missed a machine cycle");

  // Every bus request is answered in exactly one cycle.
  property p_ack;
    acc |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer timing wrong");

endmodule
`default_nettype wire

// File: testbench/ttc_pin_model.sv
// Model of the external pins that surround the timer block.
`timescale 1ns/1ns
`default_nettype none
module ttc_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] fall_i,
  input wire logic [5:0] low_i,
  output logic [5:0] pin_o
);
  // Per pin, clocks left in the current low then high phase.
  logic [4:0] cnt_q [6];

  // A fall request gives 12 clocks low, then 12 clocks high.
  // Both phases span two machine cycles, so each level is sampled.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (rst_i) begin
        cnt_q[i] <= 5'h00;
      end else if (fall_i[i]) begin
        cnt_q[i] <= 5'h18;
      end else if (cnt_q[i] != 5'h00) begin
        cnt_q[i] <= cnt_q[i] - 5'h01;
      end
    end
  end

  // Pins idle high, as pulled-up inputs do; a held low wins.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_o[i] = !(low_i[i] || (cnt_q[i] > 5'h0C));
    end
  end
endmodule
`default_nettype wire

// File: testbench/ttc_top_tb.sv
// Self-checking bench for the triple timer counter.
`timescale 1ns/1ns
`default_nettype none
module ttc_top_tb
  import ttc_pkg::*;
;
  // One ordinary case: mode, preset, and the count after one fall.
  typedef struct packed {
    logic [1:0] m;
    logic [7:0] h;
    logic [7:0] l;
    logic [7:0] eh;
    logic [7:0] el;
    logic ef;
  } ttc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_q = 1'b0;
  logic we_q = 1'b0;
  logic [7:0] adr_q = 8'h00;
  logic [31:0] dat_q = 32'h0;
  logic [31:0] rd_w;
  logic ack_w;
  logic [5:0] fall_q = 6'h00;
  logic [5:0] low_q = 6'h00;
  // Event pulses: vector 0, vector 1, done 0, done 1.
  logic [3:0] ev_q = 4'h0;
  logic [5:0] pin_w;
  // Requests: t0, t1, ext0, ext1, t2.
  logic [4:0] irq_w;
  int err_total = 0;
  int n_checks = 0;
  int cyc_n = 0;
  // Byte lane enables, and pulse counts of the two baud lines.
  logic [3:0] sel_q = 4'h1;
  logic [1:0] bp_w;
  int bp1_n = 0;
  int bp2_n = 0;
  logic [31:0] r;
  logic [31:0] v;
  // Each row presets timer 0 in counter function, then one pin fall.
  ttc_row_t rows [6] = '{
    '{MODE_13, 8'h00, 8'h1F, 8'h01, 8'h00, 1'b0},
    '{MODE_13, 8'hFF, 8'hFF, 8'h00, 8'hE0, 1'b1},
    '{MODE_16, 8'h12, 8'hFF, 8'h13, 8'h00, 1'b0},
    '{MODE_16, 8'hFF, 8'hFF, 8'h00, 8'h00, 1'b1},
    '{MODE_RL8, 8'h80, 8'hFF, 8'h80, 8'h80, 1'b1},
    '{MODE_SPLIT, 8'h55, 8'hFF, 8'h55, 8'h00, 1'b1}
  };

  always #50 clk_i = !clk_i;

  // Only byte lane 0 matters; one write with it masked must do nothing.
  ttc_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc_q), .wb_stb_i(cyc_q),
    .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(sel_q),
    .wb_dat_i(dat_q), .wb_dat_o(rd_w), .wb_ack_o(ack_w),
    .count_pin_a_i(pin_w[PN_CA]), .count_pin_b_i(pin_w[PN_CB]),
    .third_count_pin_i(pin_w[PN_C2]), .third_trigger_pin_i(pin_w[PN_TR]),
    .ext_irq_pin_a_n_i(pin_w[PN_XA]), .ext_irq_pin_b_n_i(pin_w[PN_XB]),
    .t0_vector_i(ev_q[0]), .t1_vector_i(ev_q[1]),
    .ext_irq0_done_i(ev_q[2]), .ext_irq1_done_i(ev_q[3]),
    .t0_irq_o(irq_w[0]), .t1_irq_o(irq_w[1]), .ext_irq0_o(irq_w[2]),
    .ext_irq1_o(irq_w[3]), .t2_irq_o(irq_w[4]),
    .t1_baud_pulse_o(bp_w[0]), .t2_baud_pulse_o(bp_w[1])
  );

  ttc_pin_model pins (
    .clk_i(clk_i), .rst_i(rst_i), .fall_i(fall_q), .low_i(low_q),
    .pin_o(pin_w)
  );

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compares with case equality so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk_i);
    cyc_q <= 1'b1;
    we_q <= w;
    adr_q <= a;
    dat_q <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_w !== 1'b1);
    r = rd_w;
    cyc_q <= 1'b0;
    we_q <= 1'b0;
  endtask

  // Reads a register and compares its low byte and zero upper bits.
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, r);
  endtask

  // Asks the pin model for one falling edge and lets it settle.
  task automatic fl(input int i);
    @(posedge clk_i);
    fall_q[i] <= 1'b1;
    @(posedge clk_i);
    fall_q[i] <= 1'b0;
    repeat (30) @(posedge clk_i);
  endtask

  // One-cycle event pulse from the processor side.
  task automatic ev(input int i);
    @(posedge clk_i);
    ev_q[i] <= 1'b1;
    @(posedge clk_i);
    ev_q[i] <= 1'b0;
    @(posedge clk_i);
  endtask

  // Cuts a hang short and counts the one-cycle baud pulses.
  always @(posedge clk_i) begin
    cyc_n++;
    if (bp_w[0]) begin
      bp1_n++;
    end
    if (bp_w[1]) begin
      bp2_n++;
    end
    if (cyc_n == 20000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc("tctrl rst", ADR_TCTRL, RST_BYTE);
    rc("tmode rst", ADR_TMODE, RST_BYTE);
    rc("t2ctrl rst", ADR_T2CTRL, RST_BYTE);
    wb(1'b1, 8'h3C, 8'hA5);
    rc("unmapped", 8'h3C, 8'h00);
    // Ordinary cases: every mode of timer 0 as a pin counter.
    foreach (rows[i]) begin
      wb(1'b1, ADR_TCTRL, 8'h00);
      wb(1'b1, ADR_TMODE, {6'h01, rows[i].m});
      wb(1'b1, ADR_T0HI, rows[i].h);
      wb(1'b1, ADR_T0LO, rows[i].l);
      wb(1'b1, ADR_TCTRL, 8'h10);
      fl(PN_CA);
      chk("t0 flag", {31'h0, rows[i].ef}, {31'h0, irq_w[0]});
      if (rows[i].ef) begin
        ev(0);
        chk("t0 flag clr", 32'h0, {31'h0, irq_w[0]});
      end
      rc("t0 lo", ADR_T0LO, rows[i].el);
      rc("t0 hi", ADR_T0HI, rows[i].eh);
    end
    // A stopped timer ignores the pin; restarting keeps the count.
    wb(1'b1, ADR_TCTRL, 8'h00);
    wb(1'b1, ADR_TMODE, 8'h05);
    wb(1'b1, ADR_T0LO, 8'h07);
    fl(PN_CA);
    rc("t0 stopped", ADR_T0LO, 8'h07);
    wb(1'b1, ADR_TCTRL, 8'h10);
    fl(PN_CA);
    rc("t0 resumed", ADR_T0LO, 8'h08);
    // Gate on: a low interrupt pin blocks counting.
    wb(1'b1, ADR_TMODE, 8'h0D);
    low_q[PN_XA] <= 1'b1;
    fl(PN_CA);
    rc("gate shut", ADR_T0LO, 8'h08);
    low_q[PN_XA] <= 1'b0;
    fl(PN_CA);
    rc("gate open", ADR_T0LO, 8'h09);
    // A write with byte lane 0 masked off leaves the register alone.
    sel_q <= 4'h0;
    wb(1'b1, ADR_T0LO, 8'hEE);
    sel_q <= 4'h1;
    rc("sel off", ADR_T0LO, 8'h09);
    // Edge type on both external requests, cleared when processed.
    wb(1'b1, ADR_TCTRL, 8'h05);
    fl(PN_XA);
    chk("ext0 edge", 32'h1, {31'h0, irq_w[2]});
    ev(2);
    chk("ext0 done", 32'h0, {31'h0, irq_w[2]});
    fl(PN_XB);
    chk("ext1 edge", 32'h1, {31'h0, irq_w[3]});
    ev(3);
    chk("ext1 done", 32'h0, {31'h0, irq_w[3]});
    // Level type follows the pin.
    wb(1'b1, ADR_TCTRL, 8'h00);
    low_q[PN_XB] <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("ext1 low", 32'h1, {31'h0, irq_w[3]});
    low_q[PN_XB] <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("ext1 high", 32'h0, {31'h0, irq_w[3]});
    // Timer function: about 63 clocks of run give 10 or 11 ticks.
    wb(1'b1, ADR_TMODE, 8'h11);
    wb(1'b1, ADR_T1LO, 8'h00);
    wb(1'b1, ADR_TCTRL, 8'h50);
    repeat (60) @(posedge clk_i);
    wb(1'b1, ADR_TCTRL, 8'h00);
    wb(1'b0, ADR_T1LO, 8'h00);
    v = r;
    chk("t1 ticks", 32'h1, {31'h0, (v >= 32'd9 && v <= 32'd12)});
    // Mode 3 of timer 1 holds its count although run is set.
    wb(1'b1, ADR_TMODE, 8'h30);
    wb(1'b1, ADR_TCTRL, 8'h40);
    repeat (30) @(posedge clk_i);
    wb(1'b0, ADR_T1LO, 8'h00);
    chk("t1 hold", v, r);
    // Split timer 0: its high byte overflows into the timer 1 flag.
    wb(1'b1, ADR_T0HI, 8'hFF);
    wb(1'b1, ADR_TMODE, 8'h13);
    repeat (30) @(posedge clk_i);
    chk("th0 to tf1", 32'h1, {31'h0, irq_w[1]});
    wb(1'b0, ADR_T1LO, 8'h00);
    chk("t1 runs", 32'h1, {31'h0, (r > v)});
    ev(1);
    chk("t1 flag clr", 32'h0, {31'h0, irq_w[1]});
    // Timer 1 overflow pulses the baud line but leaves its flag alone.
    wb(1'b1, ADR_T1HI, 8'hFF);
    wb(1'b1, ADR_T1LO, 8'hFF);
    repeat (20) @(posedge clk_i);
    chk("t1 baud pulse", 32'd1, bp1_n);
    chk("t1 flag split", 32'h0, {31'h0, irq_w[1]});
    // Timer 2 capture mode as a pin counter.
    wb(1'b1, ADR_TCTRL, 8'h00);
    wb(1'b1, ADR_T2CTRL, 8'h0F);
    wb(1'b1, ADR_T2LO, 8'hFF);
    wb(1'b1, ADR_T2HI, 8'hFF);
    fl(PN_C2);
    rc("t2 wrap", ADR_T2HI, 8'h00);
    rc("t2 ovf", ADR_T2CTRL, 8'h8F);
    chk("t2 irq ovf", 32'h1, {31'h0, irq_w[4]});
    wb(1'b1, ADR_T2CTRL, 8'h0F);
    chk("t2 sw clr", 32'h0, {31'h0, irq_w[4]});
    wb(1'b1, ADR_T2LO, 8'h34);
    wb(1'b1, ADR_T2HI, 8'h12);
    fl(PN_TR);
    rc("cap lo", ADR_CAPLO, 8'h34);
    rc("cap hi", ADR_CAPHI, 8'h12);
    chk("t2 irq exf", 32'h1, {31'h0, irq_w[4]});
    rc("t2 exf", ADR_T2CTRL, 8'h4F);
    // Auto-reload on rollover and on a trigger fall.
    wb(1'b1, ADR_T2CTRL, 8'h0E);
    wb(1'b1, ADR_CAPLO, 8'hCD);
    wb(1'b1, ADR_CAPHI, 8'hAB);
    wb(1'b1, ADR_T2LO, 8'hFF);
    wb(1'b1, ADR_T2HI, 8'hFF);
    fl(PN_C2);
    rc("rl lo", ADR_T2LO, 8'hCD);
    rc("rl hi", ADR_T2HI, 8'hAB);
    rc("rl ovf", ADR_T2CTRL, 8'h8E);
    wb(1'b1, ADR_T2LO, 8'h00);
    fl(PN_TR);
    rc("trig lo", ADR_T2LO, 8'hCD);
    rc("trig exf", ADR_T2CTRL, 8'hCE);
    // Baud mode through each of the four source bits in turn.
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, ADR_BAUDB, {6'h00, b == 3, b == 2});
      wb(1'b1, ADR_T2CTRL, b == 0 ? 8'h16 : (b == 1 ? 8'h26 : 8'h06));
      wb(1'b1, ADR_T2HI, 8'hFF);
      wb(1'b1, ADR_T2LO, 8'hFF);
      fl(PN_C2);
      rc("baud lo", ADR_T2LO, 8'hCD);
      wb(1'b0, ADR_T2CTRL, 8'h00);
      chk("baud ovf", 32'h0, {31'h0, r[T2_OVF]});
    end
    chk("t2 baud pulses", 32'd4, bp2_n);
    // Timer 2 in timer function counts machine cycles.
    wb(1'b1, ADR_BAUDB, 8'h00);
    wb(1'b1, ADR_T2CTRL, 8'h04);
    wb(1'b1, ADR_T2HI, 8'h00);
    wb(1'b1, ADR_T2LO, 8'h00);
    repeat (60) @(posedge clk_i);
    wb(1'b1, ADR_T2CTRL, 8'h00);
    wb(1'b0, ADR_T2LO, 8'h00);
    chk("t2 ticks", 32'h1, {31'h0, (r >= 32'd9 && r <= 32'd12)});
    // A reset in mid-run drops every flag that software has set.
    wb(1'b1, ADR_TCTRL, 8'hAF);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("irq rst", 32'h0, {27'h0, irq_w});
    rc("tctrl rst2", ADR_TCTRL, RST_BYTE);
    test_done();
  end
endmodule
`default_nettype wire
